// ### common/inv_state_pkg.sv
package inv_state_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] DELAY_OFS = 8'h08;
  localparam logic [7:0] SCREEN_OFS = 8'h0C;

  // control register fields
  localparam int CTRL_NET_EN_BIT = 0;
  localparam int CTRL_FAULT_CLR_BIT = 1;
  localparam int CTRL_PAUSE_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // default startup delay in seconds
  localparam logic [15:0] DELAY_RESET = 16'h000A;

  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int SECOND_CYCLES = CLK_HZ;
  localparam int GRID_FAULT_DELAY_S = 300;
  localparam int SETTLE_TIME_MS = 100;
  localparam int SETTLE_CYCLES = SETTLE_TIME_MS * (CLK_HZ / 1000);
  localparam int SCREEN_TIME_S = 3;
  localparam int INIT_CYCLES = 16;

  localparam int NUM_SCREENS = 6;

  typedef enum logic [3:0] {
    ST_INIT,
    ST_DISABLED,
    ST_FAULT,
    ST_LATCHED,
    ST_SLEEP,
    ST_START_DELAY,
    ST_DC_PRECHARGE,
    ST_AC_PRECHARGE,
    ST_IDLE,
    ST_TRACK
  } op_state_t;

  typedef enum logic [2:0] {
    SET_INIT,
    SET_ENERGY,
    SET_FAULT,
    SET_WARNING,
    SET_DISABLED
  } screen_set_t;

  // enable inputs
  typedef struct packed {
    logic panel_on;
    logic disconnects_closed;
    logic remote_enable;
  } enables_t;

  // sensor inputs
  typedef struct packed {
    logic fault;
    logic fault_latching;
    logic fault_grid;
    logic ground_fault_interrupter_open;
    logic warning;
    logic array_above_start;
    logic array_below_min;
    logic bus_matches_array;
    logic xfmr_magnetized;
  } sense_t;

  // contactor drive outputs
  typedef struct packed {
    logic dc_precharge;
    logic dc_main;
    logic ac_precharge;
    logic ac_main;
  } contactors_t;

endpackage

// ### rtl/inverter_operating_state_controller.sv
// Behaviour
// - only documented transitions among the operating states are taken
// - after power up, initialize runs then goes to sleep
// - panel switch off or network disable forces the disabled state
// - remote disable input asserted forces the disabled state
// - disabled goes to sleep when enabled again; disabled indication shown
// - fault while disabled goes to fault; cleared fault returns to disabled
// - any fault enters fault from every state except initialize
// - non-latching fault clears itself when condition subsides; codes displayed
// - latching fault holds latched state with codes shown until cleared
// - clearing a latched fault moves to sleep
// - sleep moves to startup delay when array rises above start threshold
// - startup delay waits a configurable interval before dc precharge
// - after a grid-interactive fault shutdown, startup delay lasts five minutes
// - dc precharge closes its contactor; advance when bus matches array
// - ac precharge closes main dc and ac precharge contactors
// - magnetized closes main ac, opens ac precharge; short delay then idle
// - idle halts conversion, shows idle, moves to tracking above start
// - idle returns to sleep when array drops below minimum
// - tracking runs converter under max power tracking; fault leaves it
// - display picks one of five screen sets by state
// - screens of a set scroll continuously
// - each pause/scroll press toggles hold and resume
// - ground fault fuse open stops operation with fault message
// - enabled only when all enables hold; any one disables
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module inverter_operating_state_controller (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire inv_state_pkg::enables_t enables,
  input wire inv_state_pkg::sense_t sense,
  input wire logic pause_button,
  output inv_state_pkg::contactors_t contactors,
  output logic converter_run,
  output logic max_power_tracking,
  output logic idle_ind,
  output logic disabled_ind,
  output logic fault_ind,
  output inv_state_pkg::screen_set_t screen_set,
  output logic [2:0] screen_index
);

  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_sync_n = rst_sync_r;

  // bus slave: zero wait states, always OKAY
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic [31:0] ctrl_r;
  logic [15:0] delay_sec_r;
  logic fault_clr_pulse;
  logic pause_sw_pulse;
  logic addr_phase;

  assign addr_phase = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_r <= addr_phase && hwrite;
      addr_r <= haddr[7:0];
    end
  end

  assign fault_clr_pulse = wr_pend_r && addr_r == inv_state_pkg::CTRL_OFS
    && hwdata[inv_state_pkg::CTRL_FAULT_CLR_BIT];
  assign pause_sw_pulse = wr_pend_r && addr_r == inv_state_pkg::CTRL_OFS && hwdata[inv_state_pkg::CTRL_PAUSE_BIT];

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl_r <= inv_state_pkg::CTRL_RESET;
      delay_sec_r <= inv_state_pkg::DELAY_RESET;
    end
    else if (wr_pend_r)
    begin
      if (addr_r == inv_state_pkg::CTRL_OFS)
        ctrl_r <= {31'h0000_0000, hwdata[inv_state_pkg::CTRL_NET_EN_BIT]};
      if (addr_r == inv_state_pkg::DELAY_OFS)
        delay_sec_r <= hwdata[15:0];
    end
  end

  inv_state_pkg::op_state_t state_r;
  inv_state_pkg::op_state_t state_nxt;
  logic [31:0] timer_r;
  logic [31:0] timer_nxt;
  logic [15:0] sec_left_r;
  logic [15:0] sec_left_nxt;
  logic grid_fault_r;
  logic latched_r;
  logic paused_r;
  logic [2:0] screen_r;
  logic [31:0] scroll_cnt_r;

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      hrdata <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
    begin
      unique case (haddr[7:0])
        inv_state_pkg::CTRL_OFS: hrdata <= ctrl_r;
        inv_state_pkg::STATUS_OFS: hrdata <= {21'h00_0000, paused_r, latched_r, grid_fault_r,
          contactors, state_r};
        inv_state_pkg::DELAY_OFS: hrdata <= {16'h0000, delay_sec_r};
        inv_state_pkg::SCREEN_OFS: hrdata <= {26'h000_0000, screen_set, screen_index};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
  logic enabled;
  logic fault_any;
  assign enabled = enables.panel_on && enables.disconnects_closed
    && enables.remote_enable && ctrl_r[inv_state_pkg::CTRL_NET_EN_BIT];
  assign fault_any = sense.fault || sense.ground_fault_interrupter_open;

  always_comb
  begin
    state_nxt = state_r;
    timer_nxt = timer_r + 32'd1;
    sec_left_nxt = sec_left_r;
    unique case (state_r)
      inv_state_pkg::ST_INIT:
      begin
        if (timer_r == 32'(inv_state_pkg::INIT_CYCLES - 1))
          state_nxt = inv_state_pkg::ST_SLEEP;
      end
      inv_state_pkg::ST_FAULT:
      begin
        timer_nxt = 32'd0;
        if (sense.fault_latching)
          state_nxt = inv_state_pkg::ST_LATCHED;
        else if (!fault_any)
          state_nxt = enabled ? inv_state_pkg::ST_SLEEP : inv_state_pkg::ST_DISABLED;
      end
      inv_state_pkg::ST_LATCHED:
      begin
        timer_nxt = 32'd0;
        if (fault_clr_pulse && !fault_any)
          state_nxt = inv_state_pkg::ST_SLEEP;
      end
      inv_state_pkg::ST_DISABLED:
      begin
        timer_nxt = 32'd0;
        if (fault_any)
          state_nxt = inv_state_pkg::ST_FAULT;
        else if (enabled)
          state_nxt = inv_state_pkg::ST_SLEEP;
      end
      default:
      begin
        if (fault_any)
        begin
          state_nxt = sense.fault_latching ? inv_state_pkg::ST_LATCHED : inv_state_pkg::ST_FAULT;
          timer_nxt = 32'd0;
        end
        else if (!enabled)
        begin
          state_nxt = inv_state_pkg::ST_DISABLED;
          timer_nxt = 32'd0;
        end
        else
        begin
          unique case (state_r)
            inv_state_pkg::ST_SLEEP:
            begin
              timer_nxt = 32'd0;
              sec_left_nxt = grid_fault_r ? 16'(inv_state_pkg::GRID_FAULT_DELAY_S) : delay_sec_r;
              if (sense.array_above_start)
                state_nxt = inv_state_pkg::ST_START_DELAY;
            end
            inv_state_pkg::ST_START_DELAY:
            begin
              if (timer_r == 32'(inv_state_pkg::SECOND_CYCLES - 1))
              begin
                timer_nxt = 32'd0;
                if (sec_left_r != 16'h0000)
                  sec_left_nxt = sec_left_r - 16'd1;
              end
              if (sec_left_r == 16'h0000)
              begin
                state_nxt = inv_state_pkg::ST_DC_PRECHARGE;
                timer_nxt = 32'd0;
              end
            end
            inv_state_pkg::ST_DC_PRECHARGE:
            begin
              timer_nxt = 32'd0;
              if (sense.bus_matches_array && sense.array_above_start)
                state_nxt = inv_state_pkg::ST_AC_PRECHARGE;
            end
            inv_state_pkg::ST_AC_PRECHARGE:
            begin
              if (!sense.xfmr_magnetized && timer_r == 32'd0)
                timer_nxt = 32'd0;
              else if (timer_r == 32'(inv_state_pkg::SETTLE_CYCLES))
              begin
                state_nxt = inv_state_pkg::ST_IDLE;
                timer_nxt = 32'd0;
              end
            end
            inv_state_pkg::ST_IDLE:
            begin
              timer_nxt = 32'd0;
              if (sense.array_below_min)
                state_nxt = inv_state_pkg::ST_SLEEP;
              else if (sense.array_above_start)
                state_nxt = inv_state_pkg::ST_TRACK;
            end
            default:
            begin
              timer_nxt = 32'd0;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_r <= inv_state_pkg::ST_INIT;
      timer_r <= 32'd0;
      sec_left_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      sec_left_r <= sec_left_nxt;
    end
  end

  // remembers a grid-interactive fault until the next startup delay finishes
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      grid_fault_r <= 1'b0;
    else if (state_r != inv_state_pkg::ST_INIT && sense.fault && sense.fault_grid)
      grid_fault_r <= 1'b1;
    else if (state_r == inv_state_pkg::ST_START_DELAY && state_nxt == inv_state_pkg::ST_DC_PRECHARGE)
      grid_fault_r <= 1'b0;
  end
  assign latched_r = state_r == inv_state_pkg::ST_LATCHED;

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      contactors <= '0;
      converter_run <= 1'b0;
      max_power_tracking <= 1'b0;
      idle_ind <= 1'b0;
      disabled_ind <= 1'b0;
      fault_ind <= 1'b0;
    end
    else
    begin
      contactors.dc_precharge <= state_nxt == inv_state_pkg::ST_DC_PRECHARGE;
      contactors.dc_main <= state_nxt inside {inv_state_pkg::ST_AC_PRECHARGE, inv_state_pkg::ST_IDLE,
        inv_state_pkg::ST_TRACK};
      contactors.ac_precharge <= state_nxt == inv_state_pkg::ST_AC_PRECHARGE
        && timer_nxt == 32'd0 && !sense.xfmr_magnetized;
      contactors.ac_main <= (state_nxt == inv_state_pkg::ST_AC_PRECHARGE && (timer_nxt != 32'd0
        || sense.xfmr_magnetized)) || state_nxt inside {inv_state_pkg::ST_IDLE, inv_state_pkg::ST_TRACK};
      converter_run <= state_nxt == inv_state_pkg::ST_TRACK;
      max_power_tracking <= state_nxt == inv_state_pkg::ST_TRACK;
      idle_ind <= state_nxt == inv_state_pkg::ST_IDLE;
      disabled_ind <= state_nxt == inv_state_pkg::ST_DISABLED;
      fault_ind <= state_nxt inside {inv_state_pkg::ST_FAULT, inv_state_pkg::ST_LATCHED};
    end
  end

  // display screen set and scrolling
  logic pause_prev_r;
  logic [2:0] set_len;
  always_comb
  begin
    unique case (state_r)
      inv_state_pkg::ST_INIT: screen_set = inv_state_pkg::SET_INIT;
      inv_state_pkg::ST_FAULT, inv_state_pkg::ST_LATCHED: screen_set = inv_state_pkg::SET_FAULT;
      inv_state_pkg::ST_DISABLED: screen_set = inv_state_pkg::SET_DISABLED;
      default: screen_set = sense.warning ? inv_state_pkg::SET_WARNING : inv_state_pkg::SET_ENERGY;
    endcase
    set_len = (screen_set == inv_state_pkg::SET_ENERGY) ? 3'(inv_state_pkg::NUM_SCREENS) : 3'd2;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pause_prev_r <= 1'b0;
      paused_r <= 1'b0;
    end
    else
    begin
      pause_prev_r <= pause_button;
      if ((pause_button && !pause_prev_r) || pause_sw_pulse)
        paused_r <= !paused_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      screen_r <= 3'd0;
      scroll_cnt_r <= 32'd0;
    end
    else if (!paused_r)
    begin
      if (scroll_cnt_r == 32'(inv_state_pkg::SCREEN_TIME_S * inv_state_pkg::SECOND_CYCLES - 1))
      begin
        scroll_cnt_r <= 32'd0;
        screen_r <= (screen_r >= set_len - 3'd1) ? 3'd0 : screen_r + 3'd1;
      end
      else
        scroll_cnt_r <= scroll_cnt_r + 32'd1;
    end
    else if (screen_r >= set_len)
      screen_r <= 3'd0;
  end

  assign screen_index = (screen_r >= set_len) ? 3'd0 : screen_r;

endmodule // inverter_operating_state_controller

// ### dv/inv_state_chk.sv
`timescale 1ns/1ps
module inv_state_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire inv_state_pkg::enables_t enables,
  input wire inv_state_pkg::sense_t sense,
  input wire inv_state_pkg::contactors_t contactors,
  input wire logic converter_run,
  input wire logic fault_ind,
  input wire inv_state_pkg::screen_set_t screen_set,
  input wire logic [2:0] screen_index
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_PANEL_OFF: assert property (!enables.panel_on |=> contactors == '0)
    else $error("contactor closed with panel off");
  AST_REMOTE_OFF: assert property (!enables.remote_enable |=> contactors == '0)
    else $error("contactor closed with remote disable");
  AST_FAULT_OPEN: assert property (sense.fault |=> contactors == '0 && !converter_run)
    else $error("contactor closed during fault");
  AST_GFI_STOP: assert property (sense.ground_fault_interrupter_open |=> !converter_run && contactors == '0)
    else $error("running with ground fault fuse open");
  AST_AC_PRE_PAIR: assert property (contactors.ac_precharge |-> contactors.dc_main && !contactors.ac_main)
    else $error("ac precharge without main dc");
  AST_AC_MAIN_SWAP: assert property ($rose(contactors.ac_main) |-> $past(contactors.ac_precharge) && !contactors.ac_precharge)
    else $error("ac main closed out of order");
  AST_DC_ORDER: assert property ($rose(contactors.dc_main) |-> $past(contactors.dc_precharge))
    else $error("main dc closed without precharge");
  AST_FAULT_SCREEN: assert property (fault_ind |-> screen_set == inv_state_pkg::SET_FAULT)
    else $error("fault without fault screens");
  AST_SCREEN_RANGE: assert property (screen_index <= 3'h5)
    else $error("screen index out of range");
endmodule // inv_state_chk

bind inverter_operating_state_controller inv_state_chk inv_state_chk_i (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .enables(enables),
  .sense(sense),
  .contactors(contactors),
  .converter_run(converter_run),
  .fault_ind(fault_ind),
  .screen_set(screen_set),
  .screen_index(screen_index)
);

// ### dv/power_stage_model.sv
`timescale 1ns/1ps
module power_stage_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire inv_state_pkg::contactors_t contactors,
  output logic bus_matches_array,
  output logic xfmr_magnetized
);
  logic [3:0] bus_cnt_r;
  logic [3:0] mag_cnt_r;
  // bus charges while any dc path is closed, discharges at once when opened
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) bus_cnt_r <= 4'h0;
    else if (!contactors.dc_precharge && !contactors.dc_main) bus_cnt_r <= 4'h0;
    else if (bus_cnt_r != 4'hF) bus_cnt_r <= bus_cnt_r + 4'h1;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) mag_cnt_r <= 4'h0;
    else if (!contactors.ac_precharge && !contactors.ac_main) mag_cnt_r <= 4'h0;
    else if (mag_cnt_r != 4'hF) mag_cnt_r <= mag_cnt_r + 4'h1;
  assign bus_matches_array = bus_cnt_r >= (slow ? 4'hE : 4'h8);
  assign xfmr_magnetized = mag_cnt_r >= (slow ? 4'hE : 4'h6);
endmodule // power_stage_model

// ### dv/inverter_operating_state_controller_tb.sv
`timescale 1ns/1ps
module inverter_operating_state_controller_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  inv_state_pkg::enables_t enables = 3'h7;
  inv_state_pkg::sense_t sense_drv = '0;
  inv_state_pkg::sense_t sense;
  inv_state_pkg::contactors_t contactors;
  inv_state_pkg::screen_set_t screen_set;
  logic [2:0] screen_index;
  logic pause_button = 1'b0;
  logic slow = 1'b0;
  logic bus_match, magnetized, run, mpt, idle_ind, disabled_ind, fault_ind;
  logic [31:0] rd;
  logic [2:0] e;
  logic p;
  int fails = 0;
  int n_compared = 0;
  int seed = 98139;
  int i;
  int k;
  always #10 ref_clk = ~ref_clk;
  always_comb
  begin
    sense = sense_drv;
    sense.bus_matches_array = bus_match;
    sense.xfmr_magnetized = magnetized;
  end
  inverter_operating_state_controller inverter_operating_state_controller_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .enables(enables),
    .sense(sense), .pause_button(pause_button), .contactors(contactors), .converter_run(run),
    .max_power_tracking(mpt), .idle_ind(idle_ind), .disabled_ind(disabled_ind), .fault_ind(fault_ind),
    .screen_set(screen_set), .screen_index(screen_index));
  power_stage_model power_stage_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .contactors(contactors), .bus_matches_array(bus_match), .xfmr_magnetized(magnetized));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  // poll the state field, bounded
  task automatic want(input logic [3:0] s);
    int n;
    for (n = 0; n < 60; n++)
    begin
      bus(1'b0, inv_state_pkg::STATUS_OFS, 32'h0);
      if (rd[3:0] === s) break;
    end
    check(rd[3:0], s);
  endtask
  task automatic end_sim;
    $display("compared=%0d failed=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    end_sim;
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    want(inv_state_pkg::ST_INIT);
    bus(1'b0, inv_state_pkg::CTRL_OFS, 32'h0);
    check(rd, inv_state_pkg::CTRL_RESET);
    bus(1'b0, inv_state_pkg::DELAY_OFS, 32'h0);
    check(rd, {16'h0, inv_state_pkg::DELAY_RESET});
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    want(inv_state_pkg::ST_SLEEP);
    for (i = 0; i < 12; i++)
    begin
      e = (i < 3) ? ~(3'h1 << i) : 3'($random(seed));
      enables <= e;
      want(e == 3'h7 ? inv_state_pkg::ST_SLEEP : inv_state_pkg::ST_DISABLED);
      check(disabled_ind, e != 3'h7);
      if (e != 3'h7) check(screen_set, inv_state_pkg::SET_DISABLED);
      bus(1'b0, inv_state_pkg::SCREEN_OFS, 32'h0);
      check(rd, {26'h0, (e == 3'h7 ? inv_state_pkg::SET_ENERGY : inv_state_pkg::SET_DISABLED), 3'h0});
      check(screen_index, 3'h0);
    end
    enables <= 3'h7;
    bus(1'b1, inv_state_pkg::CTRL_OFS, 32'h0);
    want(inv_state_pkg::ST_DISABLED);
    sense_drv.fault <= 1'b1;
    want(inv_state_pkg::ST_FAULT);
    sense_drv.fault <= 1'b0;
    want(inv_state_pkg::ST_DISABLED);
    bus(1'b1, inv_state_pkg::CTRL_OFS, 32'h1);
    want(inv_state_pkg::ST_SLEEP);
    sense_drv.fault <= 1'b1;
    enables.panel_on <= 1'b0;
    want(inv_state_pkg::ST_FAULT);
    check(fault_ind, 1'b1);
    sense_drv.fault <= 1'b0;
    enables.panel_on <= 1'b1;
    want(inv_state_pkg::ST_SLEEP);
    sense_drv.fault <= 1'b1;
    sense_drv.fault_latching <= 1'b1;
    want(inv_state_pkg::ST_LATCHED);
    sense_drv.fault <= 1'b0;
    sense_drv.fault_latching <= 1'b0;
    repeat (20) @(posedge ref_clk);
    want(inv_state_pkg::ST_LATCHED);
    bus(1'b1, inv_state_pkg::CTRL_OFS, 32'h3);
    want(inv_state_pkg::ST_SLEEP);
    sense_drv.ground_fault_interrupter_open <= 1'b1;
    want(inv_state_pkg::ST_FAULT);
    sense_drv.ground_fault_interrupter_open <= 1'b0;
    want(inv_state_pkg::ST_SLEEP);
    for (i = 0; i < 3; i++)
    begin
      bus(1'b0, inv_state_pkg::STATUS_OFS, 32'h0);
      p = rd[10];
      if (i < 2)
      begin
        pause_button <= 1'b1;
        repeat (3) @(posedge ref_clk);
        pause_button <= 1'b0;
        repeat (3) @(posedge ref_clk);
      end
      else bus(1'b1, inv_state_pkg::CTRL_OFS, 32'h5);
      bus(1'b0, inv_state_pkg::STATUS_OFS, 32'h0);
      check(rd[10], !p);
    end
    bus(1'b1, inv_state_pkg::DELAY_OFS, 32'h0);
    bus(1'b0, inv_state_pkg::DELAY_OFS, 32'h0);
    check(rd, 32'h0);
    for (i = 0; i < 2; i++)
    begin
      slow <= i[0];
      sense_drv.array_above_start <= 1'b1;
      want(inv_state_pkg::ST_DC_PRECHARGE);
      check(contactors, 4'h8);
      want(inv_state_pkg::ST_AC_PRECHARGE);
      check(contactors, 4'h6);
      check({run, mpt, idle_ind}, 3'h0);
      for (k = 0; k < 60 && contactors.ac_main !== 1'b1; k++) @(posedge ref_clk);
      check(contactors[2:0], 3'h5);
      sense_drv.fault <= 1'b1;
      want(inv_state_pkg::ST_FAULT);
      check(contactors, 4'h0);
      sense_drv.fault <= 1'b0;
      sense_drv.array_above_start <= 1'b0;
      want(inv_state_pkg::ST_SLEEP);
    end
    end_sim;
  end
endmodule // inverter_operating_state_controller_tb
